/* File: common/fps_array_if.sv */
// interface: sequencer to flash array command group
`timescale 1ns/100ps
`default_nettype none
interface fps_array_if;
  logic wr_en;        // write one word
  logic erase_en;     // erase one word to all ones
  logic [23:0] addr;  // word address
  logic [23:0] wdata; // data to write
  modport seq (output wr_en, output erase_en, output addr, output wdata);
  modport array (input wr_en, input erase_en, input addr, input wdata);
endinterface
`default_nettype wire

/* File: common/fps_pkg.sv */
// package: constants and types for the flash program/erase sequencer
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package fps_pkg;

  //----------------------------------------------------------------------------
  // register map (word indices on the plain port)
  //----------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_KEY = 4'h1;
  localparam logic [3:0] ADDR_DEST_LOWER = 4'h2;
  localparam logic [3:0] ADDR_DEST_UPPER = 4'h3;
  localparam logic [3:0] ADDR_LATCH_INDEX = 4'h4;
  localparam logic [3:0] ADDR_LATCH_LOW = 4'h5;
  localparam logic [3:0] ADDR_LATCH_HIGH = 4'h6;

  //----------------------------------------------------------------------------
  // control register fields
  //----------------------------------------------------------------------------
  localparam int BIT_START = 15;
  localparam int BIT_ENABLE = 14;
  localparam int BIT_ERROR = 13;
  localparam int BIT_IDLE_OFF = 12;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  //----------------------------------------------------------------------------
  // keys and operation codes
  //----------------------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [3:0] OP_DOUBLE = 4'h1;
  localparam logic [3:0] OP_ROW = 4'h2;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] OP_CHIP_ERASE = 4'hE;

  //----------------------------------------------------------------------------
  // array geometry and timing
  //----------------------------------------------------------------------------
  localparam int ROW_WORDS = 128;
  localparam int BLOCK_WORDS = 1024;
  localparam int DOUBLE_WORDS = 2;
  localparam logic [6:0] ROW_LAST = 7'h7F;
  localparam logic [9:0] BLOCK_LAST = 10'h3FF;
  localparam logic [23:0] ROW_ALIGN_MASK = 24'hFF_FF00;
  localparam logic [23:0] BLOCK_ALIGN_MASK = 24'hFF_F800;
  localparam logic [23:0] ERASED_WORD = 24'hFF_FFFF;
  localparam logic [23:0] USER_TOP = 24'h02_AFFE;
  localparam logic [23:0] ADDR_STEP = 24'h00_0002;
  localparam int SETTLE_NS = 100;
  localparam int CLOCK_NS = 10;
  localparam logic [7:0] SETTLE_CYCLES = 8'((SETTLE_NS + CLOCK_NS - 1) / CLOCK_NS);

  //----------------------------------------------------------------------------
  // sequencer state
  //----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FPS_IDLE,
    FPS_SETTLE,
    FPS_ERASE,
    FPS_PROGRAM,
    FPS_DONE
  } fps_state_t;

endpackage

/* File: design/fps_array_port.sv */
// module: registered flash array command stage
`timescale 1ns/100ps
`default_nettype none
module fps_array_port
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // command from sequencer
  fps_array_if.array cmd,
  // array pins
  output logic flash_wr,
  output logic flash_erase,
  output logic [23:0] flash_addr,
  output logic [23:0] flash_wdata
);
  // all state of the stage
  typedef struct packed
  {
    logic wr;
    logic erase;
    logic [23:0] addr;
    logic [23:0] wdata;
  } fps_port_st_t;

  fps_port_st_t s_q;
  fps_port_st_t s_d;

  // capture the command, retimed for the array
  always_comb
  begin
    s_d = s_q;
    s_d.wr = cmd.wr_en;
    s_d.erase = cmd.erase_en;
    s_d.addr = cmd.addr;
    s_d.wdata = cmd.wdata;
  end

  // register the stage
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end

  assign flash_wr = s_q.wr;
  assign flash_erase = s_q.erase;
  assign flash_addr = s_q.addr;
  assign flash_wdata = s_q.wdata;
endmodule
`default_nettype wire

/* File: design/fps_sequencer.sv */
// module: flash program/erase sequencer with key lock and latches
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module fps_sequencer
(
  // clock, enable and power-on reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // system
  input wire logic idle_mode,
  output logic cpu_stall,
  output logic flash_standby,
  output logic flash_power_off,
  // flash array
  output logic flash_wr,
  output logic flash_erase,
  output logic [23:0] flash_addr,
  output logic [23:0] flash_wdata
);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  // limitations: no software abort exists
  // an operation ends by itself or by power-on reset
  // chip erase walks the user range one word per cycle
  // so it runs for many thousands of cycles
  // error flag: no clear of its own, only a good start
  // one record holds every flop except the latch memory
  // reset and freeze reach every field alike
  typedef struct packed
  {
    fps_pkg::fps_state_t st;
    logic start;           // running flag, bit 15
    logic enable;          // program enable, bit 14
    logic error;           // sequence error, bit 13
    logic idle_off;        // idle power choice, bit 12
    logic [1:0] rsvd;      // reserved bits kept as written
    logic [3:0] op;        // operation select
    logic [7:0] upper;     // destination upper byte
    logic [15:0] lower;    // destination lower word
    logic key_half;        // first key seen on the previous write
    logic unlocked;        // key sequence complete
    logic [6:0] latch_idx; // latch pointer for table writes
    logic [15:0] rdata;    // read answer
    logic [9:0] count;     // words remaining after this one
    logic [7:0] settle;    // settle countdown
    logic [23:0] cur;      // current array address
    logic [3:0] run_op;    // operation latched at start
  } fps_st_t;

  fps_st_t s_q;
  fps_st_t s_d;

  // holding latches, split low word / upper byte
  logic [15:0] lat_lo_q [fps_pkg::ROW_WORDS];
  logic [7:0] lat_hi_q [fps_pkg::ROW_WORDS];

  // array command group
  fps_array_if arr ();

  //----------------------------------------------------------------------------
  // decode
  //----------------------------------------------------------------------------
  // bus decode from the current strobe and address
  // nothing here is registered: a write acts at its edge
  logic wr_ctl;
  logic wr_key;
  logic start_req;
  logic op_valid;
  logic [23:0] dest;
  logic [6:0] rd_idx;

  assign wr_ctl = reg_wr && (reg_addr == fps_pkg::ADDR_CONTROL);
  assign wr_key = reg_wr && (reg_addr == fps_pkg::ADDR_KEY);
  assign start_req = wr_ctl && reg_wdata[fps_pkg::BIT_START] && !s_q.start;
  assign dest = {s_q.upper, s_q.lower};
  // code judged as carried by the start write itself
  // only four codes are real, 0100 and the rest start nothing
  assign op_valid = (reg_wdata[3:0] == fps_pkg::OP_DOUBLE)
    || (reg_wdata[3:0] == fps_pkg::OP_ROW)
    || (reg_wdata[3:0] == fps_pkg::OP_PAGE_ERASE)
    || (reg_wdata[3:0] == fps_pkg::OP_CHIP_ERASE);
  // latch slot drained in this cycle
  // row: slot from the word offset in the row
  // double word: always slots 0 and 1, any destination
  assign rd_idx = (s_q.run_op == fps_pkg::OP_ROW) ? s_q.cur[7:1]
    : (7'(fps_pkg::DOUBLE_WORDS - 1) - s_q.count[6:0]);

  //----------------------------------------------------------------------------
  // next-state logic
  //----------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    arr.wr_en = 1'b0;
    arr.erase_en = 1'b0;
    arr.addr = s_q.cur;
    arr.wdata = {lat_hi_q[rd_idx], lat_lo_q[rd_idx]};
    s_d.rdata = '0;

    // key tracking: 55 then AA on back-to-back writes
    // reads are not writes: a poll between keys is harmless
    // any other write after the first key is stray
    // a stray write cancels unlock and raises the error
    // runs while busy too, but no start is taken then

    if (reg_wr)
    begin
      s_d.key_half = wr_key && (reg_wdata[7:0] == fps_pkg::KEY_FIRST);
      if (wr_key && s_q.key_half && (reg_wdata[7:0] == fps_pkg::KEY_SECOND))
        s_d.unlocked = 1'b1;
      else if (s_q.key_half)
      begin
        // a write wedged between the two keys spoils the sequence
        s_d.unlocked = 1'b0;
        s_d.error = 1'b1;
      end
      else if (!wr_key)
        s_d.unlocked = 1'b0;
    end

    // register writes
    // all dropped while busy, so the array never sees
    // its address or latches change under it
    // error flag is not here: software cannot write it
    if (reg_wr && !s_q.start)
    begin
      unique case (reg_addr)
        fps_pkg::ADDR_CONTROL:
        begin
          s_d.enable = reg_wdata[fps_pkg::BIT_ENABLE];
          s_d.idle_off = reg_wdata[fps_pkg::BIT_IDLE_OFF];
          s_d.rsvd = reg_wdata[11:10];
          s_d.op = reg_wdata[3:0];
          s_d.unlocked = 1'b0;
        end
        fps_pkg::ADDR_DEST_LOWER:
          s_d.lower = reg_wdata;
        fps_pkg::ADDR_DEST_UPPER:
          s_d.upper = reg_wdata[7:0];
        fps_pkg::ADDR_LATCH_INDEX:
          s_d.latch_idx = reg_wdata[6:0];
        fps_pkg::ADDR_LATCH_HIGH:
          s_d.latch_idx = s_q.latch_idx + 7'd1; // high byte closes a word
        default:
        begin
          // key and low latch word store nothing here
        end
      endcase
    end

    // start attempt
    // every condition judged in the cycle of the write
    // a refused start never reaches the settle state
    // only the error flag tells software nothing ran
    if (start_req)
    begin
      if (s_q.unlocked && reg_wdata[fps_pkg::BIT_ENABLE] && s_q.enable && op_valid)
      begin
        s_d.start = 1'b1;
        s_d.error = 1'b0;
        s_d.run_op = reg_wdata[3:0]; // code of the start write
        s_d.settle = fps_pkg::SETTLE_CYCLES;
        s_d.st = fps_pkg::FPS_SETTLE;
      end
      else
        s_d.error = 1'b1;
    end

    // read port, one cycle later
    // answer cleared every cycle: data stand one cycle only
    // the bus sees zero at all other times
    if (reg_rd)
    begin
      unique case (reg_addr)
        fps_pkg::ADDR_CONTROL:
          s_d.rdata = {s_q.start, s_q.enable, s_q.error, s_q.idle_off,
                       s_q.rsvd, 6'h00, s_q.op};
        fps_pkg::ADDR_DEST_LOWER:
          s_d.rdata = s_q.lower;
        fps_pkg::ADDR_DEST_UPPER:
          s_d.rdata = {8'h00, s_q.upper};
        fps_pkg::ADDR_LATCH_INDEX:
          s_d.rdata = {9'h000, s_q.latch_idx};
        default:
          s_d.rdata = '0; // key and latches read zero
      endcase
    end

    // operation sequencer
    // settle first, then one word per cycle
    // count runs down to zero, end point included; chip erase ends at USER_TOP
    // stall is the start bit itself, so it cannot drop
    // before the done state clears it

    unique case (s_q.st)
      fps_pkg::FPS_IDLE:
      begin
        // waiting for a valid start
      end
      fps_pkg::FPS_SETTLE:
      begin
        s_d.settle = s_q.settle - 8'd1;
        if (s_q.settle == 8'd1)
        begin
          unique case (s_q.run_op)
            fps_pkg::OP_CHIP_ERASE:
            begin
              // fixed range from zero, address registers ignored
              s_d.cur = '0;
              s_d.count = '0;
              s_d.st = fps_pkg::FPS_ERASE;
            end
            fps_pkg::OP_PAGE_ERASE:
            begin
              s_d.cur = dest & fps_pkg::BLOCK_ALIGN_MASK;
              s_d.count = fps_pkg::BLOCK_LAST;
              s_d.st = fps_pkg::FPS_ERASE;
            end
            fps_pkg::OP_ROW:
            begin
              s_d.cur = dest & fps_pkg::ROW_ALIGN_MASK;
              s_d.count = {3'b000, fps_pkg::ROW_LAST};
              s_d.st = fps_pkg::FPS_PROGRAM;
            end
            default:
            begin
              // double word: two slots at the destination
              s_d.cur = dest;
              s_d.count = 10'(fps_pkg::DOUBLE_WORDS - 1);
              s_d.st = fps_pkg::FPS_PROGRAM;
            end
          endcase
        end
      end
      fps_pkg::FPS_ERASE:
      begin
        arr.erase_en = 1'b1;
        s_d.cur = s_q.cur + fps_pkg::ADDR_STEP;
        s_d.count = s_q.count - 10'd1;
        // chip erase stops at the top of user space, sparing id, otp, executive
        if ((s_q.run_op == fps_pkg::OP_CHIP_ERASE) ? (s_q.cur == fps_pkg::USER_TOP)
            : (s_q.count == '0))
          s_d.st = fps_pkg::FPS_DONE;
      end
      fps_pkg::FPS_PROGRAM:
      begin
        arr.wr_en = 1'b1; // latches reach the array only here
        s_d.cur = s_q.cur + fps_pkg::ADDR_STEP;
        s_d.count = s_q.count - 10'd1;
        if (s_q.count == '0)
          s_d.st = fps_pkg::FPS_DONE;
      end
      fps_pkg::FPS_DONE:
      begin
        s_d.start = 1'b0; // self clear
        s_d.st = fps_pkg::FPS_IDLE;
      end
    endcase
  end

  //----------------------------------------------------------------------------
  // registers: power-on reset clears the control bits
  //----------------------------------------------------------------------------
  // latches stay out of this reset on purpose
  // holding cells power up unknown: fill every slot
  // of a row before programming it
  // clock enable low freezes the whole record
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.st <= fps_pkg::FPS_IDLE;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  //----------------------------------------------------------------------------
  // holding latches, no reset like the real cells
  //----------------------------------------------------------------------------
  // each slot is its own flop group; a later write simply overwrites
  // no reset keeps the slots cheap
  // pointer wraps after slot 127
  genvar gi;
  generate
    for (gi = 0; gi < fps_pkg::ROW_WORDS; gi++)
    begin : g_lat
      always_ff @(posedge clock)
      begin
        if (clk_en && reg_wr && !s_q.start && (s_q.latch_idx == 7'(gi)))
        begin
          if (reg_addr == fps_pkg::ADDR_LATCH_LOW)
            lat_lo_q[gi] <= reg_wdata;
          if (reg_addr == fps_pkg::ADDR_LATCH_HIGH)
            lat_hi_q[gi] <= reg_wdata[7:0];
        end
      end
    end
  endgenerate

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign cpu_stall = s_q.start;
  // idle: power off or standby as bit 12 says
  // combinational, so the array follows idle at once
  // never both high, never high outside idle
  assign flash_power_off = idle_mode && s_q.idle_off;
  assign flash_standby = idle_mode && !s_q.idle_off;

  // retimed array command
  fps_array_port u_port
  (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .cmd(arr.array),
    .flash_wr(flash_wr),
    .flash_erase(flash_erase),
    .flash_addr(flash_addr),
    .flash_wdata(flash_wdata)
  );

  // the interface's seq side is driven from the comb process above
  // the port stage adds one cycle to every array command
  // address, data and strobe stay aligned through it

endmodule
`default_nettype wire

/* File: sim/fps_sequencer_bench.sv */
// testbench: self-checking scenarios for the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fps_sequencer_bench;
  //--------------------------------------------------------------------------
  // signals and design
  //--------------------------------------------------------------------------
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1; // dropped once to check freezing
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic idle_mode = 1'b0;
  logic [15:0] reg_rdata, v;
  logic cpu_stall, flash_standby, flash_power_off, flash_wr, flash_erase;
  logic [23:0] flash_addr, flash_wdata, er_first, er_last;
  logic [47:0] wq[$]; // captured array writes {addr, data}
  int n_erase = 0;
  int n_mismatch = 0;
  int num_checks = 0;

  fps_sequencer dut_u (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .idle_mode(idle_mode), .cpu_stall(cpu_stall),
    .flash_standby(flash_standby), .flash_power_off(flash_power_off),
    .flash_wr(flash_wr), .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata));

  always #5 clock = ~clock;

  // array monitor; sees values settled during the previous cycle
  always @(posedge clock)
  begin
    if (flash_wr === 1'b1)
      wq.push_back({flash_addr, flash_wdata});
    if (flash_erase === 1'b1)
    begin
      if (n_erase == 0)
        er_first = flash_addr;
      er_last = flash_addr;
      n_erase++;
    end
  end

  //--------------------------------------------------------------------------
  // bus tasks
  //--------------------------------------------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobe stays up so writes can run back to back
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  task automatic keys;
    wr(fps_pkg::ADDR_KEY, 16'h0055);
    wr(fps_pkg::ADDR_KEY, 16'h00AA);
  endtask

  // keyed start, status read while busy, bounded wait for completion
  task automatic run_op(input logic [15:0] ctl, input int limit);
    int i;
    keys();
    wr(fps_pkg::ADDR_CONTROL, ctl);
    rd(fps_pkg::ADDR_CONTROL, v);
    idle(1);
    #1;
    chk(cpu_stall, 1'b1);
    chk(v[15:13], 3'b110);
    for (i = 0; i < limit && cpu_stall === 1'b1; i++)
      @(posedge clock);
    #1;
    chk(cpu_stall, 1'b0);
    idle(3);
  endtask

  task automatic refused;
    idle(3);
    rd(fps_pkg::ADDR_CONTROL, v);
    chk({cpu_stall, v[15], v[13], n_erase == 0, wq.size() == 0}, 5'b00111);
  endtask

  //--------------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------------
  task automatic t_regs;
    rd(fps_pkg::ADDR_CONTROL, v);
    chk(v, 16'h0000);
    wr(fps_pkg::ADDR_KEY, 16'h0055);
    rd(fps_pkg::ADDR_KEY, v);
    chk(v, 16'h0000);
    rd(4'hF, v);
    chk(v, 16'h0000);
    idle_mode <= 1'b1;
    // lone first key above makes this write stray: error set
    wr(fps_pkg::ADDR_CONTROL, 16'h1FF5);
    rd(fps_pkg::ADDR_CONTROL, v);
    chk(v, 16'h3C05);
    chk({flash_standby, flash_power_off}, 2'b01);
    wr(fps_pkg::ADDR_CONTROL, 16'h2000);
    rd(fps_pkg::ADDR_CONTROL, v);
    chk(v, 16'h2000);
    chk({flash_standby, flash_power_off}, 2'b10);
    clk_en <= 1'b0;
    wr(fps_pkg::ADDR_CONTROL, 16'h4003);
    clk_en <= 1'b1;
    rd(fps_pkg::ADDR_CONTROL, v);
    chk(v, 16'h2000);
    idle_mode <= 1'b0;
  endtask

  // two words, the first latch written twice so the later value wins
  task automatic t_double;
    wq.delete();
    wr(fps_pkg::ADDR_CONTROL, 16'h4001);
    wr(fps_pkg::ADDR_LATCH_INDEX, 16'h0000);
    wr(fps_pkg::ADDR_LATCH_LOW, 16'hDEAD);
    wr(fps_pkg::ADDR_LATCH_HIGH, 16'h00EE);
    wr(fps_pkg::ADDR_LATCH_INDEX, 16'h0000);
    wr(fps_pkg::ADDR_LATCH_LOW, 16'h1357);
    wr(fps_pkg::ADDR_LATCH_HIGH, 16'h0024);
    wr(fps_pkg::ADDR_LATCH_LOW, 16'h9BDF);
    wr(fps_pkg::ADDR_LATCH_HIGH, 16'h0068);
    wr(fps_pkg::ADDR_DEST_LOWER, 16'h2344);
    wr(fps_pkg::ADDR_DEST_UPPER, 16'h0001);
    run_op(16'hC001, 60);
    chk(wq.size(), 2);
    chk(wq[0], 48'h0123_4424_1357);
    chk(wq[1], 48'h0123_4668_9BDF);
    rd(fps_pkg::ADDR_CONTROL, v);
    chk(v, 16'h4001);
  endtask

  task automatic t_bad;
    logic [3:0] ops [4] = '{4'h4, 4'h0, 4'h7, 4'hF};
    int k;
    wq.delete();
    n_erase = 0;
    wr(fps_pkg::ADDR_CONTROL, 16'hC002);
    refused();
    keys();
    wr(fps_pkg::ADDR_CONTROL, 16'h8002);
    refused();
    wr(fps_pkg::ADDR_KEY, 16'h0055);
    wr(fps_pkg::ADDR_DEST_LOWER, 16'h0000);
    wr(fps_pkg::ADDR_KEY, 16'h00AA);
    wr(fps_pkg::ADDR_CONTROL, 16'hC002);
    refused();
    for (k = 0; k < 4; k++)
    begin
      keys();
      wr(fps_pkg::ADDR_CONTROL, {12'hC00, ops[k]});
      refused();
    end
    keys();
    wr(fps_pkg::ADDR_CONTROL, 16'h4002);
    wr(fps_pkg::ADDR_CONTROL, 16'hC002);
    refused();
  endtask

  // full row from an unaligned destination; latches filled in one pass, slot 0 to 127
  task automatic t_row;
    int i;
    wq.delete();
    wr(fps_pkg::ADDR_CONTROL, 16'h4002);
    wr(fps_pkg::ADDR_LATCH_INDEX, 16'h0000);
    for (i = 0; i < 128; i++)
    begin
      wr(fps_pkg::ADDR_LATCH_LOW, 16'hA000 + 16'(i));
      wr(fps_pkg::ADDR_LATCH_HIGH, {8'h00, 8'(i) ^ 8'h5A});
    end
    wr(fps_pkg::ADDR_DEST_LOWER, 16'h0340);
    wr(fps_pkg::ADDR_DEST_UPPER, 16'h0000);
    run_op(16'hC002, 300);
    chk(wq.size(), 128);
    for (i = 0; i < wq.size(); i++)
      chk(wq[i], {24'h00_0300 + 24'(2 * i), 8'(i) ^ 8'h5A, 16'hA000 + 16'(i)});
    rd(fps_pkg::ADDR_CONTROL, v);
    chk(v, 16'h4002);
  endtask

  task automatic t_erase;
    n_erase = 0;
    wr(fps_pkg::ADDR_CONTROL, 16'h4003);
    wr(fps_pkg::ADDR_DEST_LOWER, 16'h1A40);
    wr(fps_pkg::ADDR_DEST_UPPER, 16'h0000);
    run_op(16'hC003, 1300);
    chk(n_erase, 1024);
    chk({er_first, er_last}, 48'h0018_0000_1FFE);
  endtask

  // chip erase ignores the address; a power-on reset cuts it short
  task automatic t_chip;
    int i;
    n_erase = 0;
    wr(fps_pkg::ADDR_CONTROL, 16'h400E);
    wr(fps_pkg::ADDR_DEST_LOWER, 16'h2344);
    wr(fps_pkg::ADDR_DEST_UPPER, 16'h0001);
    keys();
    wr(fps_pkg::ADDR_CONTROL, 16'hC00E);
    idle(1);
    for (i = 0; i < 40 && n_erase == 0; i++)
      @(posedge clock);
    chk(er_first, 24'h00_0000);
    arst_n <= 1'b0;
    idle(2);
    arst_n <= 1'b1;
    idle(1);
    rd(fps_pkg::ADDR_CONTROL, v);
    chk({cpu_stall, v}, 17'h0_0000);
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    idle(1);
    t_regs();
    t_double();
    t_bad();
    t_row();
    t_erase();
    t_chip();
    summarize();
  end

  // watchdog: the whole run needs about 1600 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule

bind fps_sequencer fps_sequencer_sva chk_u (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .idle_mode(idle_mode), .cpu_stall(cpu_stall),
  .flash_standby(flash_standby), .flash_power_off(flash_power_off),
  .flash_wr(flash_wr), .flash_erase(flash_erase), .flash_addr(flash_addr),
  .flash_wdata(flash_wdata));
`default_nettype wire

/* File: sim/fps_sequencer_sva.sv */
// checker: port-level assertions for the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fps_sequencer_sva
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // system side
  input wire logic idle_mode,
  input wire logic cpu_stall,
  input wire logic flash_standby,
  input wire logic flash_power_off,
  // flash array side
  input wire logic flash_wr,
  input wire logic flash_erase,
  input wire logic [23:0] flash_addr,
  input wire logic [23:0] flash_wdata
);
  //--------------------------------------------------------------------------
  // helper logic
  //--------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  localparam int STALL_MAX = 200000; // well above a whole chip erase
  logic key55, keyaa, ctl_wr, op_ok; // decoded bus events
  logic last55_q; // last accepted write was the first key
  logic unl_q; // key pair complete, no write since
  logic [31:0] stall_cnt_q; // cycles spent stalled
  assign key55 = clk_en && reg_wr && reg_addr == fps_pkg::ADDR_KEY && reg_wdata == 16'h0055;
  assign keyaa = clk_en && reg_wr && reg_addr == fps_pkg::ADDR_KEY && reg_wdata == 16'h00AA;
  assign ctl_wr = clk_en && reg_wr && reg_addr == fps_pkg::ADDR_CONTROL;
  assign op_ok = reg_wdata[3:0] inside {4'h1, 4'h2, 4'h3, 4'hE};

  // unlock as software sees it; reads never break it, any other write does
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last55_q <= 1'b0;
      unl_q <= 1'b0;
      stall_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      if (clk_en && reg_wr)
      begin
        last55_q <= key55;
        unl_q <= keyaa && last55_q;
      end
      stall_cnt_q <= cpu_stall ? stall_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  //--------------------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------------------
  sequence s_key_pair;
    key55 ##1 keyaa;
  endsequence
  sequence s_good_start;
    ctl_wr && reg_wdata[15] && reg_wdata[14] && op_ok && !cpu_stall;
  endsequence

  chk_start_accept: assert property (s_key_pair ##1 s_good_start |=> cpu_stall[*3])
    else $error("keyed start did not stall the processor");
  chk_start_refuse: assert property (ctl_wr && reg_wdata[15] && !cpu_stall &&
    !(reg_wdata[14] && op_ok && unl_q) |=> !cpu_stall)
    else $error("improper start launched an operation");
  chk_stall_holds: assert property ($rose(cpu_stall) |-> cpu_stall[*8])
    else $error("stall dropped before settling ended");
  chk_stall_bound: assert property (stall_cnt_q < STALL_MAX)
    else $error("operation never finished");
  chk_array_busy: assert property ((flash_wr || flash_erase) |-> cpu_stall || $past(cpu_stall))
    else $error("array command outside an operation");
  chk_idle_power: assert property ((flash_standby || flash_power_off) == idle_mode
    && !(flash_standby && flash_power_off))
    else $error("idle power outputs inconsistent");
  chk_key_reads_zero: assert property (clk_en && reg_rd &&
    reg_addr == fps_pkg::ADDR_KEY |=> reg_rdata == 16'h0000)
    else $error("key register read back a value");
  chk_unimpl_zero: assert property (clk_en && reg_rd &&
    reg_addr == fps_pkg::ADDR_CONTROL |=> reg_rdata[9:4] == 6'h00)
    else $error("unimplemented control bits not zero");
  chk_busy_status: assert property (clk_en && reg_rd && cpu_stall &&
    reg_addr == fps_pkg::ADDR_CONTROL |=> reg_rdata[15:13] == 3'b110)
    else $error("busy status bits wrong");
  chk_addr_step: assert property ((flash_wr && $past(flash_wr)) ||
    (flash_erase && $past(flash_erase)) |-> flash_addr == $past(flash_addr) + 24'h00_0002)
    else $error("array address did not step by two");
endmodule
`default_nettype wire
